// [core/t1ra_fdl.sv]
/*
  Receive data link byte collector: full, pattern match and abort pulses.
  Assumes bitStb is a one-cycle pulse per received data link bit.
*/
module t1ra_fdl import t1ra_pkg::*; (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       bitStb,
  input  wire logic       bitVal,
  input  wire logic [7:0] patA,
  input  wire logic [7:0] patB,
  output logic            fullPulse,
  output logic            matchPulse,
  output logic            abortPulse
);

  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic [3:0] ones_q;
  logic [7:0] byteNow;

  assign byteNow = {shift_q[6:0], bitVal};

  // byte assembly; byte boundary every eight link bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q    <= 8'h00;
      bitCnt_q   <= 3'h0;
      fullPulse  <= 1'b0;
      matchPulse <= 1'b0;
    end else begin
      fullPulse  <= 1'b0;
      matchPulse <= 1'b0;
      if (bitStb) begin
        shift_q  <= byteNow;
        bitCnt_q <= bitCnt_q + 3'h1;
        if (bitCnt_q == FDL_LAST_BIT) begin
          fullPulse  <= 1'b1;
          matchPulse <= (byteNow == patA) || (byteNow == patB);
        end
      end
    end
  end

  // run of ones, independent of byte alignment
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_q     <= 4'h0;
      abortPulse <= 1'b0;
    end else begin
      abortPulse <= 1'b0;
      if (bitStb) begin
        if (!bitVal) begin
          ones_q <= 4'h0;
        end else if (ones_q == FDL_ABORT_ONES - 4'h1) begin
          ones_q     <= 4'h0;
          abortPulse <= 1'b1;
        end else begin
          ones_q <= ones_q + 4'h1;
        end
      end
    end
  end

endmodule // t1ra_fdl

// [core/t1ra_sync.sv]
/*
  Two flip-flop synchroniser for a group of level inputs.
  Assumes each bit is stable long enough to be caught by the 50 MHz clock.
*/
module t1ra_sync import t1ra_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // t1ra_sync

// [core/t1ra_top.sv]
/*
  T1 receive alarm detection and event status with an APB register slave.
  Assumes line pins change around the falling edge of the recovered clock,
  which runs well below a quarter of the 50 MHz system clock.
*/
// Register access over APB is this design's own decision.
module t1ra_top import t1ra_pkg::*; #(
  parameter int AIS_WIN_BITS = AIS_WINDOW_BITS,
  parameter int SEC_SHORT    = SEC_SHORT_BITS,
  parameter int SEC_LONG     = SEC_LONG_BITS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        rclkPin,
  input  wire t1ra_line_t  linePins,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             rxAisAlarm,
  output logic             rxRemoteAlarm,
  output logic             rxNoSignalAlarm
);

  localparam int LW = $bits(t1ra_line_t);

  logic            rclkSync;
  logic            rclkDly_q;
  logic            bitStb;
  t1ra_line_t      lineSync;
  t1ra_line_t      ln;
  logic [LW-1:0]   lineSyncBits;
  logic            lof_q;
  logic            txMfDly_q;
  logic            txEmptyDly_q;

  // line pins and recovered clock through two flops each
  t1ra_sync #(.W(1)) u_clkSync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (rclkPin),
    .dout   (rclkSync)
  );
  t1ra_sync #(.W(LW)) u_lineSync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (linePins),
    .dout   (lineSyncBits)
  );
  assign lineSync = t1ra_line_t'(lineSyncBits);
  assign ln       = lineSync;

  // line bit strobe on each recovered clock rise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rclkDly_q <= 1'b0;
    end else begin
      rclkDly_q <= rclkSync;
    end
  end
  assign bitStb = rclkSync & ~rclkDly_q;

  // blue alarm: zero count over a 3 ms window of line bits
  logic [CNT_W-1:0] aisBits_q;
  logic [CNT_W-1:0] aisZeros_q;
  logic [CNT_W-1:0] aisZerosNow;
  logic             ais_q;
  assign aisZerosNow = aisZeros_q + {{(CNT_W-1){1'b0}}, ~ln.data};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aisBits_q  <= '0;
      aisZeros_q <= '0;
      ais_q      <= 1'b0;
    end else if (bitStb) begin
      if (aisBits_q == CNT_W'(AIS_WIN_BITS - 1)) begin
        aisBits_q  <= '0;
        aisZeros_q <= '0;
        // framed all ones carries F-bit zeros well above five per window
        if (aisZerosNow <= AIS_SET_MAX_ZEROS) begin
          ais_q <= 1'b1;
        end else if (aisZerosNow >= AIS_CLR_MIN_ZEROS) begin
          ais_q <= 1'b0;
        end
      end else begin
        aisBits_q  <= aisBits_q + 24'h000001;
        aisZeros_q <= aisZerosNow;
      end
    end
  end

  // yellow, bit-2 method: zeros among 256 consecutive channel bit 2s
  logic [8:0] y2Chans_q;
  logic [8:0] y2Zeros_q;
  logic [8:0] y2ZerosNow;
  logic       yelBit2_q;
  assign y2ZerosNow = y2Zeros_q + {8'h00, ~ln.data};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      y2Chans_q <= 9'h000;
      y2Zeros_q <= 9'h000;
      yelBit2_q <= 1'b0;
    end else if (bitStb && ln.chanBit2) begin
      if (y2Chans_q == YEL_WIN_CHANS - 9'h001) begin
        y2Chans_q <= 9'h000;
        y2Zeros_q <= 9'h000;
        yelBit2_q <= (y2ZerosNow >= YEL_SET_MIN);
      end else begin
        y2Chans_q <= y2Chans_q + 9'h001;
        y2Zeros_q <= y2ZerosNow;
      end
    end
  end

  // yellow, twelfth F-bit method: two alike in a row flip the state
  logic [1:0] fOnes_q;
  logic [1:0] fZeros_q;
  logic       yelFbit_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fOnes_q   <= 2'h0;
      fZeros_q  <= 2'h0;
      yelFbit_q <= 1'b0;
    end else if (bitStb && ln.fbit12) begin
      if (ln.data) begin
        fZeros_q <= 2'h0;
        if (fOnes_q == FBIT_RUN - 2'h1) begin
          yelFbit_q <= 1'b1;
        end else begin
          fOnes_q <= fOnes_q + 2'h1;
        end
      end else begin
        fOnes_q <= 2'h0;
        if (fZeros_q == FBIT_RUN - 2'h1) begin
          yelFbit_q <= 1'b0;
        end else begin
          fZeros_q <= fZeros_q + 2'h1;
        end
      end
    end
  end

  // yellow, ESF: 16-bit data link patterns compared against 00ff
  logic [15:0] esfShift_q;
  logic [3:0]  esfBit_q;
  logic [4:0]  esfRun_q;
  logic [4:0]  esfWin_q;
  logic [4:0]  esfHits_q;
  logic        yelEsf_q;
  logic [15:0] esfWord;
  logic        esfHit;
  logic [4:0]  esfHitsNow;
  assign esfWord    = {esfShift_q[14:0], ln.data};
  assign esfHit     = (esfWord == ESF_YEL_PATTERN);
  assign esfHitsNow = esfHits_q + {4'h0, esfHit};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      esfShift_q <= 16'h0000;
      esfBit_q   <= 4'h0;
      esfRun_q   <= 5'h00;
      esfWin_q   <= 5'h00;
      esfHits_q  <= 5'h00;
      yelEsf_q   <= 1'b0;
    end else if (bitStb && ln.fdlBit) begin
      esfShift_q <= esfWord;
      esfBit_q   <= esfBit_q + 4'h1;
      if (esfBit_q == ESF_PAT_LAST_BIT) begin
        esfRun_q <= esfHit ? esfRun_q + 5'h01 : 5'h00;
        if (esfHit && esfRun_q == ESF_SET_RUN - 5'h01) begin
          yelEsf_q <= 1'b1;
          esfRun_q <= 5'h00;
        end
        if (esfWin_q == ESF_WIN_PATTERNS - 5'h01) begin
          esfWin_q  <= 5'h00;
          esfHits_q <= 5'h00;
          if (esfHitsNow <= ESF_CLR_MAX) begin
            yelEsf_q <= 1'b0;
          end
        end else begin
          esfWin_q  <= esfWin_q + 5'h01;
          esfHits_q <= esfHitsNow;
        end
      end
    end
  end

  // red alarm: zero run to set, ones in a window opened by a one to clear
  logic [7:0] redZeros_q;
  logic [6:0] redWin_q;
  logic [4:0] redOnes_q;
  logic       redOpen_q;
  logic       red_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      redZeros_q <= 8'h00;
      redWin_q   <= 7'h00;
      redOnes_q  <= 5'h00;
      redOpen_q  <= 1'b0;
      red_q      <= 1'b0;
    end else if (bitStb) begin
      redZeros_q <= ln.data ? 8'h00 : redZeros_q;
      if (!ln.data && redZeros_q != RED_SET_ZEROS) begin
        redZeros_q <= redZeros_q + 8'h01;
      end
      if (!red_q) begin
        redOpen_q <= 1'b0;
        if (!ln.data && redZeros_q == RED_SET_ZEROS - 8'h01) begin
          red_q <= 1'b1;
        end
      end else if (!redOpen_q) begin
        // window starts only at the first mark
        if (ln.data) begin
          redOpen_q <= 1'b1;
          redWin_q  <= 7'h01;
          redOnes_q <= 5'h01;
        end
      end else begin
        if (ln.data && redOnes_q == RED_CLR_ONES - 5'h01) begin
          red_q     <= 1'b0;
          redOpen_q <= 1'b0;
        end else if (redWin_q == RED_CLR_WIN - 7'h01) begin
          redOpen_q <= 1'b0;
        end else begin
          redWin_q  <= redWin_q + 7'h01;
          redOnes_q <= redOnes_q + {4'h0, ln.data};
        end
      end
    end
  end

  // one-second tick: 999, 999, 1002 ms counted in line bits
  logic [CNT_W-1:0] secCnt_q;
  logic [1:0]       secPhase_q;
  logic             secTick;
  logic [CNT_W-1:0] secLimit;
  assign secLimit = (secPhase_q == SEC_LONG_PHASE) ? CNT_W'(SEC_LONG - 1)
                                                   : CNT_W'(SEC_SHORT - 1);
  assign secTick  = bitStb && (secCnt_q == secLimit);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      secCnt_q   <= '0;
      secPhase_q <= 2'h0;
    end else if (secTick) begin
      secCnt_q   <= '0;
      secPhase_q <= (secPhase_q == SEC_LONG_PHASE) ? 2'h0 : secPhase_q + 2'h1;
    end else if (bitStb) begin
      secCnt_q <= secCnt_q + 24'h000001;
    end
  end

  // robbed-bit signaling memory, slot counter restarts each multiframe
  logic [SIG_SLOTS-1:0] sigMem_q;
  logic [6:0]           sigIdx_q;
  logic                 sigChange;
  assign sigChange = bitStb && ln.sigBit && (sigMem_q[sigIdx_q] != ln.data);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sigMem_q <= '0;
      sigIdx_q <= 7'h00;
    end else if (bitStb) begin
      if (ln.rxMf) begin
        sigIdx_q <= 7'h00;
      end else if (ln.sigBit && sigIdx_q != 7'(SIG_SLOTS - 1)) begin
        sigIdx_q <= sigIdx_q + 7'h01;
      end
      if (ln.sigBit) begin
        sigMem_q[sigIdx_q] <= ln.data;
      end
    end
  end

  // data link byte events
  logic       fdlFull;
  logic       fdlMatch;
  logic       fdlAbort;
  logic [7:0] patA_q;
  logic [7:0] patB_q;
  t1ra_fdl u_fdl (
    .clk        (clk),
    .arst_n     (arst_n),
    .bitStb     (bitStb && ln.fdlBit),
    .bitVal     (ln.data),
    .patA       (patA_q),
    .patB       (patB_q),
    .fullPulse  (fdlFull),
    .matchPulse (fdlMatch),
    .abortPulse (fdlAbort)
  );

  // transmit side events are edges of synchronised levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txMfDly_q    <= 1'b0;
      txEmptyDly_q <= 1'b0;
      lof_q        <= 1'b0;
    end else begin
      txMfDly_q    <= ln.txMf;
      txEmptyDly_q <= ln.txEmpty;
      lof_q        <= ln.outOfFrame;
    end
  end

  // APB slave: one wait-free access, answer in the first access cycle
  logic [7:0] ctrl_q;
  logic [7:0] event_q;
  logic [7:0] eventSet;
  logic [7:0] alarmOne;
  logic [7:0] idx;
  logic       yelSel;
  logic       accessDone;
  logic       readEvent;
  assign idx        = t1ra_index(paddr);
  assign accessDone = psel && penable && pready;
  assign readEvent  = accessDone && !pwrite && idx == IDX_EVENT_TWO;

  // yellow source chosen by framing mode and method select
  assign yelSel = ctrl_q[CTRL_ESF] ? yelEsf_q
                : (ctrl_q[CTRL_YEL_METHOD] ? yelFbit_q : yelBit2_q);

  always_comb begin
    alarmOne         = 8'h00;
    alarmOne[A1_AIS] = ais_q;
    alarmOne[A1_YEL] = yelSel;
    alarmOne[A1_RED] = red_q;
    alarmOne[A1_LOF] = lof_q;
    eventSet            = 8'h00;
    eventSet[E2_RXMF]   = bitStb && ln.rxMf;
    eventSet[E2_TXMF]   = ln.txMf && !txMfDly_q;
    eventSet[E2_SEC]    = secTick;
    eventSet[E2_RXFULL] = fdlFull;
    eventSet[E2_TXEMPT] = ln.txEmpty && !txEmptyDly_q;
    eventSet[E2_MATCH]  = fdlMatch;
    eventSet[E2_ABORT]  = fdlAbort;
    eventSet[E2_SIGCHG] = sigChange;
  end

  // sticky events; a read clears only the bits it reported, held in prdata
  // during the access cycle, so an event landing in the setup cycle survives
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_q <= 8'h00;
    end else begin
      event_q <= (readEvent ? (event_q & ~prdata[7:0]) : event_q) | eventSet;
    end
  end

  // writable control and match patterns
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RESET;
      patA_q <= PAT_RESET;
      patB_q <= PAT_RESET;
    end else if (accessDone && pwrite) begin
      case (idx)
        IDX_CTRL:  ctrl_q <= pwdata[7:0];
        IDX_PAT_A: patA_q <= pwdata[7:0];
        IDX_PAT_B: patB_q <= pwdata[7:0];
        default:   ;
      endcase
    end
  end

  // answer path; unmapped index returns zero with an error
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (idx)
          IDX_ALARM_ONE: prdata <= {24'h000000, alarmOne};
          IDX_EVENT_TWO: prdata <= {24'h000000, event_q};
          IDX_CTRL:      prdata <= {24'h000000, ctrl_q};
          IDX_PAT_A:     prdata <= {24'h000000, patA_q};
          IDX_PAT_B:     prdata <= {24'h000000, patB_q};
          default:       pslverr <= 1'b1;
        endcase
      end
    end
  end

  // AIS, yellow and red alarm levels also brought out as pins; loss of frame is not
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxAisAlarm      <= 1'b0;
      rxRemoteAlarm   <= 1'b0;
      rxNoSignalAlarm <= 1'b0;
    end else begin
      rxAisAlarm      <= ais_q;
      rxRemoteAlarm   <= yelSel;
      rxNoSignalAlarm <= red_q;
    end
  end

endmodule // t1ra_top

// [inc/t1ra_pkg.sv]
/*
  Constants, register map and carrier types for the T1 receive alarm and
  event status block. Assumes a 1.544 Mbit/s line whose recovered clock and
  framer position strobes arrive as pins asynchronous to the 50 MHz clock.
*/
package t1ra_pkg;

  // line timing
  localparam longint LINE_RATE_HZ    = 1544000;
  localparam longint AIS_WINDOW_MS   = 3;
  localparam longint SEC_SHORT_MS    = 999;
  localparam longint SEC_LONG_MS     = 1002;
  localparam int     AIS_WINDOW_BITS = int'(LINE_RATE_HZ * AIS_WINDOW_MS / 1000);
  localparam int     SEC_SHORT_BITS  = int'(LINE_RATE_HZ * SEC_SHORT_MS / 1000);
  localparam int     SEC_LONG_BITS   = int'(LINE_RATE_HZ * SEC_LONG_MS / 1000);
  localparam int     CNT_W           = 24;

  // alarm thresholds
  localparam logic [CNT_W-1:0] AIS_SET_MAX_ZEROS = 24'h000005;
  localparam logic [CNT_W-1:0] AIS_CLR_MIN_ZEROS = 24'h000006;
  localparam logic [8:0]       YEL_WIN_CHANS     = 9'h100;
  localparam logic [8:0]       YEL_SET_MIN       = 9'h0fe;
  localparam logic [15:0]      ESF_YEL_PATTERN   = 16'h00ff;
  localparam logic [4:0]       ESF_SET_RUN       = 5'h10;
  localparam logic [4:0]       ESF_WIN_PATTERNS  = 5'h10;
  localparam logic [4:0]       ESF_CLR_MAX       = 5'h0e;
  localparam logic [3:0]       ESF_PAT_LAST_BIT  = 4'hf;
  localparam logic [7:0]       RED_SET_ZEROS     = 8'hc0;
  localparam logic [6:0]       RED_CLR_WIN       = 7'h70;
  localparam logic [4:0]       RED_CLR_ONES      = 5'h0e;
  localparam logic [1:0]       FBIT_RUN          = 2'h2;
  localparam logic [1:0]       SEC_LONG_PHASE    = 2'h2;

  // data link and signaling
  localparam logic [2:0] FDL_LAST_BIT   = 3'h7;
  localparam logic [3:0] FDL_ABORT_ONES = 4'h8;
  localparam int         SIG_SLOTS      = 96;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ALARM_ONE = 8'h20;
  localparam logic [7:0] IDX_EVENT_TWO = 8'h21;
  localparam logic [7:0] IDX_CTRL      = 8'h40;
  localparam logic [7:0] IDX_PAT_A     = 8'h41;
  localparam logic [7:0] IDX_PAT_B     = 8'h42;

  // alarm status bit positions
  localparam int A1_AIS = 3;
  localparam int A1_YEL = 2;
  localparam int A1_RED = 1;
  localparam int A1_LOF = 0;
  // event status bit positions
  localparam int E2_RXMF   = 7;
  localparam int E2_TXMF   = 6;
  localparam int E2_SEC    = 5;
  localparam int E2_RXFULL = 4;
  localparam int E2_TXEMPT = 3;
  localparam int E2_MATCH  = 2;
  localparam int E2_ABORT  = 1;
  localparam int E2_SIGCHG = 0;
  // control bit positions
  localparam int CTRL_YEL_METHOD = 2;
  localparam int CTRL_ESF        = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PAT_RESET  = 8'h00;

  // line-side pins, sampled together on every system clock; receive bits and strobes are used at each recovered clock rise
  typedef struct packed {
    logic data;       // recovered bit, 1 = mark
    logic chanBit2;   // bit is bit 2 of a channel
    logic fbit12;     // bit is the twelfth framing bit
    logic fdlBit;     // bit is a data link bit
    logic sigBit;     // bit is a robbed signaling bit
    logic rxMf;       // first bit of a receive multiframe
    logic outOfFrame; // framer not synchronised
    logic txMf;       // transmit multiframe boundary
    logic txEmpty;    // transmit data link buffer empty
  } t1ra_line_t;

  // byte address to register index
  function automatic logic [7:0] t1ra_index(input logic [11:0] addr);
    return addr[9:2];
  endfunction

endpackage

// [verif/t1ra_line_model.sv]
/*
  Line partner: recovered clock and framer strobes, bits on demand.
  Assumes the bench calls send; the clock stands still between calls.
*/
module t1ra_line_model import t1ra_pkg::*; (
  input  wire logic  clk,
  output logic       rclkPin,
  output t1ra_line_t linePins
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line before the first bit
  initial begin
    rclkPin = 1'b0;
    linePins = '0;
  end
  // pins move at the fall, so they are settled at the rise
  task automatic send(input logic [8:0] v, input int n);
    repeat (n) begin
      @(posedge clk);
      linePins <= t1ra_line_t'(v);
      rclkPin  <= 1'b0;
      repeat (4) @(posedge clk);
      rclkPin <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    rclkPin <= 1'b0;
  endtask
endmodule // t1ra_line_model

// [verif/t1ra_top_props.sv]
/*
  Port-level checks of the alarm block: bus handshake and alarm pins.
  Assumes a bind onto t1ra_top; sees its ports only.
*/
module t1ra_top_props import t1ra_pkg::*; (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        rclkPin,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxAisAlarm,
  input wire logic        rxRemoteAlarm,
  input wire logic        rxNoSignalAlarm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] al;
  logic [2:0] st;
  // pins and read data in status bit order
  assign al = {rxAisAlarm, rxRemoteAlarm, rxNoSignalAlarm};
  assign st = prdata[3:1];
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_once_a: assert property (pready |=> !pready) else $error("ready held");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("err data");
  hole_err_a: assert property (psel && !penable && paddr == 12'h004 |=> pslverr)
    else $error("hole not refused");
  map_ok_a: assert property (psel && !penable && paddr == 12'h084 |=> !pslverr)
    else $error("mapped refused");
  // pins and status are registered from the same state at the same edge; the later phase is also accepted
  status_copy_a: assert property (pready && paddr == 12'h080 |->
    st == al or ##1 $past(st) == al) else $error("pins differ from status");
  // alarms only move shortly after a line clock edge or a control write
  line_quiet_a: assert property (($stable(rclkPin) && !psel) [*8] |-> $stable(al))
    else $error("alarm moved without line clock");
endmodule // t1ra_top_props
bind t1ra_top t1ra_top_props u_props (.clk(clk), .arst_n(arst_n), .rclkPin(rclkPin),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxAisAlarm(rxAisAlarm), .rxRemoteAlarm(rxRemoteAlarm),
  .rxNoSignalAlarm(rxNoSignalAlarm));

// [verif/t1ra_top_tb.sv]
/*
  Self-checking bench for t1ra_top: registers, alarms and events.
  Assumes short window and tick parameters and the line model.
*/
module t1ra_top_tb import t1ra_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic [31:0] rnd = 32'hf49c;
  logic        pready, pslverr, ais, yel, red, rclkPin, e;
  logic [7:0]  seen = 8'h00;
  t1ra_line_t  linePins;
  int          err_total = 0;
  int          checked = 0;
  // 50 MHz system clock
  always #10 clk = ~clk;
  t1ra_line_model m (.clk(clk), .rclkPin(rclkPin), .linePins(linePins));
  t1ra_top #(.AIS_WIN_BITS(64), .SEC_SHORT(200), .SEC_LONG(203)) dut (.clk(clk),
    .arst_n(arst_n), .rclkPin(rclkPin), .linePins(linePins), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxAisAlarm(ais), .rxRemoteAlarm(yel),
    .rxNoSignalAlarm(red));
  // helpers: random source and expected alarm word
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] aw(input logic [3:0] x);
    return {28'h0, x};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one bus transfer; waits for ready, only the watchdog ends a dead wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp(rdv, x);
  endtask
  // line bits, then status read and alarm pins
  task automatic step(input logic [8:0] v, input int n, input logic [3:0] x);
    m.send(v, n);
    repeat (4) @(posedge clk);
    rd(12'h080, aw(x));
    cmp({29'h0, ais, yel, red}, {29'h0, x[3:1]});
  endtask
  // tick bit is gathered apart since its phase is not tracked
  task automatic ev(input logic [7:0] x);
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h084, 32'h0);
    seen = seen | rdv[7:0];
    cmp(rdv & 32'hffffffdf, {24'h0, x});
  endtask
  task automatic pat(input logic g);
    m.send(9'h020, 8);
    m.send(g ? 9'h120 : 9'h020, 8);
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(12'h080, 32'h0);
    rd(12'h004, 32'h0);
    cmp({31'h0, e}, 32'h1);
    rnd = xs(rnd);
    apb(1'b1, 12'h104, rnd);
    apb(1'b1, 12'h004, 32'h0);
    rd(12'h104, {24'h0, rnd[7:0]});
    apb(1'b1, 12'h108, 32'hff);
    step(9'h000, 191, 4'h0);
    step(9'h000, 1, 4'h2);
    step(9'h100, 13, 4'h2);
    step(9'h100, 1, 4'h0);
    m.send(9'h100, 50);
    m.send(9'h000, 5);
    step(9'h100, 59, 4'h8);
    cmp({31'h0, rdv[3] & rdv[0]}, 32'h0);
    m.send(9'h000, 6);
    step(9'h100, 58, 4'h0);
    repeat (2) begin
      m.send(9'h080, 127);
      m.send(9'h180, 1);
    end
    step(9'h000, 0, 4'h4);
    repeat (3) begin
      m.send(9'h080, 84);
      m.send(9'h180, 1);
    end
    step(9'h080, 1, 4'h0);
    apb(1'b1, 12'h100, 32'h04);
    rd(12'h100, 32'h04);
    step(9'h140, 1, 4'h0);
    step(9'h140, 1, 4'h4);
    step(9'h040, 1, 4'h4);
    step(9'h040, 1, 4'h0);
    apb(1'b1, 12'h100, 32'h08);
    ev(8'h00);
    repeat (15) pat(1'b1);
    step(9'h000, 0, 4'h0);
    pat(1'b1);
    step(9'h000, 0, 4'h4);
    repeat (14) pat(1'b1);
    repeat (2) pat(1'b0);
    step(9'h000, 0, 4'h0);
    ev(8'h16);
    rd(12'h084, 32'h0);
    m.send(9'h11b, 1);
    ev(8'hc9);
    step(9'h104, 1, 4'h1);
    cmp({31'h0, seen[5]}, 32'h1);
    tally_and_finish();
  end
endmodule // t1ra_top_tb
